// [src/chl_pkg.sv]
// chl_pkg: register map, field positions, reset values and states
package chl_pkg;

   // ***************************************************************
   // register map (byte addresses)
   // ***************************************************************
   localparam int          AW          = 6;
   localparam int          DW          = 32;
   localparam logic [5:0]  CMD_OFF     = 6'h00;
   localparam logic [5:0]  MODE_OFF    = 6'h04;
   localparam logic [5:0]  BLK_OFF     = 6'h08;
   localparam logic [5:0]  DATA_OFF    = 6'h0C;
   localparam logic [5:0]  STAT_OFF    = 6'h10;
   localparam logic [5:0]  MASK_OFF    = 6'h14;
   localparam logic [5:0]  RXCNT_OFF   = 6'h18;
   localparam logic [5:0]  TXCNT_OFF   = 6'h1C;
   localparam logic [5:0]  DMACTL_OFF  = 6'h20;

   // ***************************************************************
   // field positions
   // ***************************************************************
   localparam int          CMD_R1B     = 6;
   localparam int          CMD_DATA    = 7;
   localparam int          CMD_WRITE   = 8;
   localparam int          MODE_SLOTB  = 0;
   localparam int          MODE_WIDE   = 1;
   localparam int          MODE_HDUP   = 2;
   localparam int          BLK_CNT_LSB = 16;
   localparam int          DMA_RX_EN   = 0;
   localparam int          DMA_TX_EN   = 1;
   localparam int          ST_CMDDONE  = 0;
   localparam int          ST_DATADONE = 1;
   localparam int          ST_SDIO     = 2;
   localparam int          ST_RXEND    = 3;
   localparam int          ST_RXFULL   = 4;
   localparam int          ST_TXEND    = 5;
   localparam int          ST_TXEMPTY  = 6;
   localparam int          ST_DTOUT    = 7;
   localparam int          ST_BUSY     = 8;

   // ***************************************************************
   // reset values and counts
   // ***************************************************************
   localparam logic [2:0]  MODE_RST    = 3'h0;
   localparam logic [8:0]  MASK_RST    = 9'h000;
   localparam logic [8:0]  STAT_RST    = 9'h078;
   localparam logic [6:0]  CMD_LAST    = 7'h5F;
   localparam logic [15:0] MIN_WR_B    = 16'h000C;
   localparam logic [5:0]  CMD_STOP    = 6'h0C;

   typedef enum logic [2:0] {
      S_IDLE, S_CMD, S_BUSY, S_WSTART, S_RX, S_TX
   } chl_state_type;

   // only the stop command waits out the busy after its response
   function automatic logic busy_honoured(input logic [5:0] idx);
      return idx == CMD_STOP;
   endfunction : busy_honoured

endpackage : chl_pkg

// [src/chl_link_sync.sv]
// chl_link_sync: card clock and data line synchroniser, clock edge finder
`timescale 1ns/1ps
module chl_link_sync (
   input  wire logic       clk_sys_i,
   input  wire logic       rst_n_i,
   input  wire logic       card_clk_i,
   input  wire logic [7:0] dat_i,
   output logic            cclk_rise_o,
   output logic [7:0]      dat_o
);

   logic [8:0] meta_q;
   logic [8:0] sync_q;
   logic       clk_old_q;

   // ***************************************************************
   // two flops, then edge detect on the second stage only
   // ***************************************************************
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         meta_q    <= 9'h1FF;
         sync_q    <= 9'h1FF;
         clk_old_q <= 1'b1;
      end else begin
         meta_q    <= {card_clk_i, dat_i};
         sync_q    <= meta_q;
         clk_old_q <= sync_q[8];
      end
   end

   assign cclk_rise_o = sync_q[8] & ~clk_old_q;
   assign dat_o       = sync_q[7:0];

endmodule : chl_link_sync

// [src/chl_card_host.sv]
// chl_card_host: card host interface engine with its dma counters
`timescale 1ns/1ps
module chl_card_host (
   input  wire logic        clk_sys_i,
   input  wire logic        rst_n_i,
   input  wire logic [5:0]  reg_addr_i,
   input  wire logic [31:0] reg_wdata_i,
   input  wire logic        reg_wr_i,
   input  wire logic        reg_rd_i,
   output logic      [31:0] reg_rdata_o,
   output logic             irq_o,
   input  wire logic        card_clk_i,
   input  wire logic [7:0]  dat_i,
   output logic             dat0_o,
   output logic             dat0_oe_o,
   output logic             slot_b_sel_o
);

   chl_pkg::chl_state_type state_q;
   chl_pkg::chl_state_type state_d;

   logic [8:0]  cmd_q;
   logic [2:0]  mode_q;
   logic [11:0] blk_len_q;
   logic [11:0] blk_cnt_q;
   logic [31:0] tx_word_q;
   logic [31:0] tx_sh_q;
   logic [31:0] rx_q;
   logic [8:0]  stat_q;
   logic [8:0]  mask_q;
   logic [15:0] rx_cnt_q;
   logic [15:0] tx_cnt_q;
   logic [1:0]  dma_en_q;
   logic        en_seen_q;
   logic [6:0]  cnt_q;
   logic [23:0] bytes_q;
   logic [31:0] rdata_q;
   logic        irq_q;
   logic        dat0_q;
   logic        oe_q;

   // ***************************************************************
   // link sampling
   // ***************************************************************
   logic       cclk_rise;
   logic [7:0] dat_s;

   chl_link_sync u_sync (
      .clk_sys_i   (clk_sys_i),
      .rst_n_i     (rst_n_i),
      .card_clk_i  (card_clk_i),
      .dat_i       (dat_i),
      .cclk_rise_o (cclk_rise),
      .dat_o       (dat_s)
   );

   // ***************************************************************
   // decode
   // ***************************************************************
   wire        wr_cmd   = reg_wr_i & (reg_addr_i == chl_pkg::CMD_OFF);
   wire        wr_mode  = reg_wr_i & (reg_addr_i == chl_pkg::MODE_OFF);
   wire        wr_blk   = reg_wr_i & (reg_addr_i == chl_pkg::BLK_OFF);
   wire        wr_data  = reg_wr_i & (reg_addr_i == chl_pkg::DATA_OFF);
   wire        wr_stat  = reg_wr_i & (reg_addr_i == chl_pkg::STAT_OFF);
   wire        wr_mask  = reg_wr_i & (reg_addr_i == chl_pkg::MASK_OFF);
   wire        wr_rxc   = reg_wr_i & (reg_addr_i == chl_pkg::RXCNT_OFF);
   wire        wr_txc   = reg_wr_i & (reg_addr_i == chl_pkg::TXCNT_OFF);
   wire        wr_dma   = reg_wr_i & (reg_addr_i == chl_pkg::DMACTL_OFF);
   wire        slot_b   = mode_q[chl_pkg::MODE_SLOTB];
   wire        wide     = mode_q[chl_pkg::MODE_WIDE];
   wire        hdup     = mode_q[chl_pkg::MODE_HDUP];
   wire [3:0]  sel_dat  = slot_b ? dat_s[7:4] : dat_s[3:0];
   wire        is_idle  = state_q == chl_pkg::S_IDLE;
   // a new command is taken when idle, or as any command, stop or not,
   // that frees a read stalled on its start bit
   wire        take_cmd = wr_cmd & (is_idle |
                          (state_q == chl_pkg::S_WSTART));
   wire        cmd_end  = (state_q == chl_pkg::S_CMD) & cclk_rise &
                          (cnt_q == chl_pkg::CMD_LAST);
   wire [5:0]  idx      = cmd_q[5:0];
   wire        r1b      = cmd_q[chl_pkg::CMD_R1B];
   wire        has_data = cmd_q[chl_pkg::CMD_DATA];
   wire        is_write = cmd_q[chl_pkg::CMD_WRITE];
   wire        xfer     = ((state_q == chl_pkg::S_RX) |
                           (state_q == chl_pkg::S_TX)) & cclk_rise;
   wire        byte_end = xfer & (cnt_q[2:0] == 3'h7);
   wire        word_end = xfer & (cnt_q[4:0] == 5'h1F);
   wire        last_b   = byte_end & (bytes_q == 24'h000001);
   wire [23:0] total    = 24'(blk_len_q * blk_cnt_q);
   // short write counters refuse the data phase
   wire        wr_short = tx_cnt_q < chl_pkg::MIN_WR_B;
   wire        rx_dec   = byte_end & (state_q == chl_pkg::S_RX) &
                          dma_en_q[chl_pkg::DMA_RX_EN] & (rx_cnt_q != 0);
   wire        tx_dec   = byte_end & (state_q == chl_pkg::S_TX) &
                          dma_en_q[chl_pkg::DMA_TX_EN] & (tx_cnt_q != 0);
   wire        rx_hit   = rx_dec & (rx_cnt_q == 16'h0001);
   wire        tx_hit   = tx_dec & (tx_cnt_q == 16'h0001);
   // in half duplex a counter reload leaves stale flags behind until
   // some channel has been enabled once
   wire        clr_ok   = ~hdup | en_seen_q;
   wire        rx_en_w  = wr_dma & reg_wdata_i[chl_pkg::DMA_RX_EN];
   wire        tx_en_w  = wr_dma & reg_wdata_i[chl_pkg::DMA_TX_EN];
   wire        rx_clr   = (wr_rxc & (reg_wdata_i[15:0] != 0) & clr_ok) |
                          (rx_en_w & (rx_cnt_q != 0));
   wire        tx_clr   = (wr_txc & (reg_wdata_i[15:0] != 0) & clr_ok) |
                          (tx_en_w & (tx_cnt_q != 0));
   // 1-bit bus on slot b reads an idle line, so nothing is caught
   wire        sdio_ln  = (wide | ~slot_b) ? sel_dat[1] : 1'b1;
   wire        sdio_set = is_idle & cclk_rise & ~sdio_ln;
   // no access timer exists behind this flag
   wire        dto_set  = 1'b0;

   wire [8:0] set_v = {1'b0, dto_set, tx_hit, tx_hit, rx_hit, rx_hit,
                       sdio_set, last_b, cmd_end};
   wire [8:0] w1c_v = wr_stat ? {1'b0, reg_wdata_i[7], 4'h0,
                                 reg_wdata_i[2:0]} : 9'h000;
   wire [8:0] dclr_v = {2'h0, tx_clr, tx_clr, rx_clr, rx_clr, 3'h0};
   wire [8:0] stat_d = set_v | (stat_q & ~w1c_v & ~dclr_v);

   // ***************************************************************
   // command and data sequencer
   // ***************************************************************
   always_comb begin
      state_d = state_q;
      unique case (state_q)
         chl_pkg::S_IDLE:
            if (take_cmd) state_d = chl_pkg::S_CMD;
         chl_pkg::S_CMD:
            if (cmd_end) begin
               if (r1b & chl_pkg::busy_honoured(idx))
                  state_d = chl_pkg::S_BUSY;
               else if (!has_data || total == 0)
                  state_d = chl_pkg::S_IDLE;
               else if (!is_write)
                  state_d = chl_pkg::S_WSTART;
               else if (wr_short)
                  state_d = chl_pkg::S_IDLE;
               else
                  state_d = chl_pkg::S_TX;
            end
         chl_pkg::S_BUSY:
            if (cclk_rise & sel_dat[0]) state_d = chl_pkg::S_IDLE;
         chl_pkg::S_WSTART:
            if (take_cmd) state_d = chl_pkg::S_CMD;
            else if (cclk_rise & ~sel_dat[0])
               state_d = chl_pkg::S_RX;
         chl_pkg::S_RX,
         chl_pkg::S_TX:
            if (last_b) state_d = chl_pkg::S_IDLE;
      endcase
   end

   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state_q <= chl_pkg::S_IDLE;
         cnt_q   <= 7'h00;
         bytes_q <= 24'h000000;
      end else begin
         state_q <= state_d;
         if (take_cmd || (state_q != state_d)) cnt_q <= 7'h00;
         else if (cclk_rise) cnt_q <= cnt_q + 7'h01;
         if (cmd_end) bytes_q <= total;
         else if (byte_end) bytes_q <= bytes_q - 24'h000001;
      end
   end

   // ***************************************************************
   // data shifters; no buffering, a late data word is simply resent
   // ***************************************************************
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         tx_sh_q <= 32'h00000000;
         rx_q    <= 32'h00000000;
         dat0_q  <= 1'b1;
         oe_q    <= 1'b0;
      end else begin
         if (cmd_end || word_end) tx_sh_q <= tx_word_q;
         else if (xfer) tx_sh_q <= {tx_sh_q[30:0], 1'b1};
         if (xfer && state_q == chl_pkg::S_RX)
            rx_q <= {rx_q[30:0], sel_dat[0]};
         // driven whatever the card shows on the line
         oe_q   <= state_d == chl_pkg::S_TX;
         dat0_q <= (state_d == chl_pkg::S_TX) ?
                   ((cmd_end || word_end) ? tx_word_q[31] :
                    (xfer ? tx_sh_q[30] : tx_sh_q[31])) : 1'b1;
      end
   end

   // ***************************************************************
   // registers, dma counters and flags
   // ***************************************************************
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cmd_q     <= 9'h000;
         mode_q    <= chl_pkg::MODE_RST;
         blk_len_q <= 12'h000;
         blk_cnt_q <= 12'h000;
         tx_word_q <= 32'h00000000;
         mask_q    <= chl_pkg::MASK_RST;
         // counters reset empty, so the dma end and buffer flags start set
         stat_q    <= chl_pkg::STAT_RST;
         rx_cnt_q  <= 16'h0000;
         tx_cnt_q  <= 16'h0000;
         dma_en_q  <= 2'h0;
         en_seen_q <= 1'b0;
      end else begin
         if (take_cmd) cmd_q <= reg_wdata_i[8:0];
         if (wr_mode && is_idle) mode_q <= reg_wdata_i[2:0];
         if (wr_blk) begin
            blk_len_q <= reg_wdata_i[11:0];
            blk_cnt_q <= reg_wdata_i[chl_pkg::BLK_CNT_LSB +: 12];
         end
         if (wr_data) tx_word_q <= reg_wdata_i;
         if (wr_mask) mask_q <= reg_wdata_i[8:0];
         stat_q <= stat_d;
         if (wr_rxc) rx_cnt_q <= reg_wdata_i[15:0];
         else if (rx_dec) rx_cnt_q <= rx_cnt_q - 16'h0001;
         if (wr_txc) tx_cnt_q <= reg_wdata_i[15:0];
         else if (tx_dec) tx_cnt_q <= tx_cnt_q - 16'h0001;
         if (wr_dma) dma_en_q <= reg_wdata_i[1:0];
         if (rx_en_w || tx_en_w) en_seen_q <= 1'b1;
      end
   end

   // ***************************************************************
   // read port and interrupt
   // ***************************************************************
   wire [8:0]  stat_rd = {~is_idle, stat_q[7:0]};
   wire [31:0] rd_mux =
      (reg_addr_i == chl_pkg::CMD_OFF)    ? {23'h0, cmd_q} :
      (reg_addr_i == chl_pkg::MODE_OFF)   ? {29'h0, mode_q} :
      (reg_addr_i == chl_pkg::BLK_OFF)    ? {4'h0, blk_cnt_q,
                                             4'h0, blk_len_q} :
      (reg_addr_i == chl_pkg::DATA_OFF)   ? rx_q :
      (reg_addr_i == chl_pkg::STAT_OFF)   ? {23'h0, stat_rd} :
      (reg_addr_i == chl_pkg::MASK_OFF)   ? {23'h0, mask_q} :
      (reg_addr_i == chl_pkg::RXCNT_OFF)  ? {16'h0, rx_cnt_q} :
      (reg_addr_i == chl_pkg::TXCNT_OFF)  ? {16'h0, tx_cnt_q} :
      (reg_addr_i == chl_pkg::DMACTL_OFF) ? {30'h0, dma_en_q} :
      32'h00000000;

   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rdata_q <= 32'h00000000;
         irq_q   <= 1'b0;
      end else begin
         rdata_q <= reg_rd_i ? rd_mux : 32'h00000000;
         irq_q   <= |(stat_d[7:0] & mask_q[7:0]);
      end
   end

   assign reg_rdata_o  = rdata_q;
   assign irq_o        = irq_q;
   assign dat0_o       = dat0_q;
   assign dat0_oe_o    = oe_q;
   assign slot_b_sel_o = mode_q[chl_pkg::MODE_SLOTB];

   // ***************************************************************
   // assertions
   // ***************************************************************
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!rst_n_i);

   chk_r1b_no_wait: assert property (
      cmd_end && !chl_pkg::busy_honoured(idx) |=>
         state_q != chl_pkg::S_BUSY)
      else $error("busy waited for a non-stop command");
   chk_conflict_drive: assert property (
      state_q == chl_pkg::S_TX |-> dat0_oe_o)
      else $error("write data not driven during busy");
   chk_stop_busy_entry: assert property (
      cmd_end && r1b && idx == chl_pkg::CMD_STOP |=>
         state_q == chl_pkg::S_BUSY)
      else $error("stop command skipped its busy wait");
   chk_stop_busy_hold: assert property (
      state_q == chl_pkg::S_BUSY && !(cclk_rise && sel_dat[0]) |=>
         state_q == chl_pkg::S_BUSY)
      else $error("busy wait left while card busy");
   chk_sdio_slot_b: assert property (
      slot_b && !wide |=> !$rose(stat_q[chl_pkg::ST_SDIO]))
      else $error("sdio interrupt caught on slot b");
   chk_timeout_never: assert property (
      !stat_q[chl_pkg::ST_DTOUT])
      else $error("data timeout flag rose");
   chk_short_write: assert property (
      cmd_end && has_data && is_write && wr_short |=>
         state_q == chl_pkg::S_IDLE ##1 !dat0_oe_o)
      else $error("short write was started");
   chk_halfdup_clear: assert property (
      hdup && !en_seen_q && wr_rxc && !rx_hit && !rx_en_w &&
      stat_q[chl_pkg::ST_RXEND] |=> stat_q[chl_pkg::ST_RXEND])
      else $error("rx end flag cleared before channel enable");
   chk_irq_level: assert property (
      irq_o == |({1'b0, stat_q[7:0]} & $past(mask_q)))
      else $error("interrupt output does not follow status");

   cov_stop_busy: cover property (state_q == chl_pkg::S_BUSY);
   cov_write_data: cover property (state_q == chl_pkg::S_TX ##1 last_b);
   cov_read_stop: cover property (state_q == chl_pkg::S_WSTART &&
                                  take_cmd);
   cov_sdio: cover property (sdio_set);

endmodule : chl_card_host

// [testbench/chl_card_model.sv]
// chl_card_model: card on the far side, its clock and pulled-up data lines
`timescale 1ns/1ps
module chl_card_model (
   input  wire logic       run_i,
   input  wire logic       slot_b_i,
   input  wire logic       busy_i,
   input  wire logic       sdio_irq_i,
   output logic            card_clk_o,
   output logic [7:0]      dat_o
);
   logic [3:0] pull;

   // ***************************************************************
   // card clock: 400 ns period, held low while no frame runs
   // ***************************************************************
   initial begin
      card_clk_o = 1'b0;
      #13;
      forever begin
         #200;
         card_clk_o = run_i ? ~card_clk_o : 1'b0;
      end
   end

   // ***************************************************************
   // data lines: released lines rest high on their pull-ups
   // ***************************************************************
   // only the selected slot is disturbed, the other slot stays idle
   assign pull  = {2'h0, sdio_irq_i, busy_i};
   assign dat_o = slot_b_i ? ~{pull, 4'h0} : ~{4'h0, pull};
endmodule : chl_card_model

// [testbench/chl_card_host_tb.sv]
// chl_card_host_tb: self-checking bench for the card host block
`timescale 1ns/1ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin n_errors++; \
   $display("BAD %0t got %h exp %h", $time, g, e); end end
module chl_card_host_tb;
   // ***************************************************************
   // clock, reset and wiring
   // ***************************************************************
   logic        clk_sys_i  = 1'b0;
   logic        rst_n_i    = 1'b0;
   logic [5:0]  addr       = 6'h00;
   logic [31:0] wdata      = 32'h0000_0000;
   logic        wr_s       = 1'b0;
   logic        rd_s       = 1'b0;
   logic        run        = 1'b0;
   logic        busy_c     = 1'b0;
   logic        irq_c      = 1'b0;
   logic [31:0] rdata;
   logic [31:0] r;
   logic        irq;
   logic        cclk;
   logic        dat0;
   logic        dat0_oe;
   logic        slot_b;
   logic [7:0]  card_dat;
   logic [7:0]  host_pull;
   logic [7:0]  dat_w;
   logic [31:0] cap        = 32'h0000_0000;
   int          n_errors   = 0;
   int          num_checks = 0;
   int          oe_cnt     = 0;
   int          k0;
   int          i;
   int          idx [6]    = '{7, 28, 29, 38, 42, 56};

   always #25 clk_sys_i = ~clk_sys_i;
   always @(posedge clk_sys_i) if (dat0_oe) oe_cnt <= oe_cnt + 1;
   // card side: a driven line 0 is taken on each card clock rise
   always @(posedge cclk) if (dat0_oe) cap <= {cap[30:0], dat0};

   // both parties may pull the selected line 0 low: wired level
   assign host_pull = (dat0_oe && !dat0) ? (slot_b ? 8'h10 : 8'h01) : 8'h00;
   assign dat_w     = card_dat & ~host_pull;

   chl_card_host i_chl_card_host (
      .clk_sys_i    (clk_sys_i),
      .rst_n_i      (rst_n_i),
      .reg_addr_i   (addr),
      .reg_wdata_i  (wdata),
      .reg_wr_i     (wr_s),
      .reg_rd_i     (rd_s),
      .reg_rdata_o  (rdata),
      .irq_o        (irq),
      .card_clk_i   (cclk),
      .dat_i        (dat_w),
      .dat0_o       (dat0),
      .dat0_oe_o    (dat0_oe),
      .slot_b_sel_o (slot_b)
   );

   chl_card_model i_chl_card_model (
      .run_i        (run),
      .slot_b_i     (slot_b),
      .busy_i       (busy_c),
      .sdio_irq_i   (irq_c),
      .card_clk_o   (cclk),
      .dat_o        (card_dat)
   );

   // ***************************************************************
   // bus tasks
   // ***************************************************************
   task automatic finish_test();
      if (n_errors == 0 && num_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : finish_test

   task automatic wr(input logic [5:0] a, input logic [31:0] d);
      @(posedge clk_sys_i);
      addr  <= a;
      wdata <= d;
      wr_s  <= 1'b1;
      @(posedge clk_sys_i);
      wr_s  <= 1'b0;
   endtask : wr

   task automatic rd(input logic [5:0] a);
      @(posedge clk_sys_i);
      addr <= a;
      rd_s <= 1'b1;
      @(posedge clk_sys_i);
      rd_s <= 1'b0;
      #1 r = rdata;
   endtask : rd

   // polls status; a bit that never comes counts as a mismatch
   task automatic wait_bit(input int b, input logic v);
      int n;
      n = 0;
      rd(chl_pkg::STAT_OFF);
      while (r[b] !== v && n < 3000) begin
         rd(chl_pkg::STAT_OFF);
         n++;
      end
      if (r[b] !== v) begin
         n_errors++;
         finish_test();
      end
   endtask : wait_bit

   task automatic cmd(input logic [31:0] c);
      wr(chl_pkg::STAT_OFF, 32'h0000_0001);
      wr(chl_pkg::CMD_OFF, c);
      wait_bit(chl_pkg::ST_CMDDONE, 1'b1);
   endtask : cmd

   task automatic stat_after(input int n);
      repeat (n) @(posedge clk_sys_i);
      rd(chl_pkg::STAT_OFF);
   endtask : stat_after

   // ***************************************************************
   // scenarios
   // ***************************************************************
   initial begin
      repeat (8) @(posedge clk_sys_i);
      `CHK({irq, dat0, dat0_oe, slot_b}, 4'h4)
      rst_n_i <= 1'b1;
      run     <= 1'b1;
      rd(chl_pkg::MODE_OFF);
      `CHK(r, 32'h0000_0000)
      rd(chl_pkg::MASK_OFF);
      `CHK(r, 32'h0000_0000)
      wr(6'h24, 32'hFFFF_FFFF);
      rd(6'h24);
      `CHK(r, 32'h0000_0000)
      // sdio interrupt on slot A, 1-bit slot B, 4-bit slot B
      irq_c <= 1'b1;
      wait_bit(chl_pkg::ST_SDIO, 1'b1);
      `CHK(r[chl_pkg::ST_SDIO], 1'b1)
      irq_c <= 1'b0;
      repeat (20) @(posedge clk_sys_i);
      wr(chl_pkg::STAT_OFF, 32'h0000_0004);
      wr(chl_pkg::MODE_OFF, 32'h0000_0001);
      irq_c <= 1'b1;
      stat_after(300);
      `CHK(r[chl_pkg::ST_SDIO], 1'b0)
      `CHK(slot_b, 1'b1)
      wr(chl_pkg::MODE_OFF, 32'h0000_0003);
      wait_bit(chl_pkg::ST_SDIO, 1'b1);
      `CHK(r[chl_pkg::ST_SDIO], 1'b1)
      irq_c <= 1'b0;
      repeat (20) @(posedge clk_sys_i);
      wr(chl_pkg::STAT_OFF, 32'h0000_0004);
      wr(chl_pkg::MODE_OFF, 32'h0000_0000);
      // busy after R1b ignored for all but the stop command
      busy_c <= 1'b1;
      foreach (idx[k]) begin
         cmd(32'h0000_0040 | 32'(idx[k]));
         stat_after(40);
         `CHK(r[chl_pkg::ST_BUSY], 1'b0)
      end
      cmd(32'h0000_004C);
      stat_after(40);
      `CHK(r[chl_pkg::ST_BUSY], 1'b1)
      busy_c <= 1'b0;
      wait_bit(chl_pkg::ST_BUSY, 1'b0);
      `CHK(r[chl_pkg::ST_BUSY], 1'b0)
      // read with no start bit stalls; a stop frees it
      wr(chl_pkg::BLK_OFF, 32'h0001_000C);
      cmd(32'h0000_0091);
      stat_after(2000);
      `CHK(r[8:7], 2'h2)
      cmd(32'h0000_000C);
      stat_after(40);
      `CHK(r[chl_pkg::ST_BUSY], 1'b0)
      // write while the card still holds line 0 busy
      busy_c <= 1'b1;
      wr(chl_pkg::BLK_OFF, 32'h0001_000C);
      wr(chl_pkg::TXCNT_OFF, 32'h0000_000C);
      wr(chl_pkg::DATA_OFF, 32'hA5C3_0F96);
      wr(chl_pkg::DMACTL_OFF, 32'h0000_0002);
      wr(chl_pkg::MASK_OFF, 32'h0000_0060);
      cmd(32'h0000_01F8);
      for (i = 0; i < 2000 && !dat0_oe; i++) @(posedge clk_sys_i);
      `CHK(dat0_oe, 1'b1)
      `CHK(dat0, 1'b1)
      busy_c <= 1'b0;
      wait_bit(chl_pkg::ST_DATADONE, 1'b1);
      `CHK(r[6:5], 2'h3)
      `CHK(cap, 32'hA5C3_0F96)
      `CHK(irq, 1'b1)
      // interrupt masked, unmasked and cleared
      wr(chl_pkg::MASK_OFF, 32'h0000_0000);
      rd(chl_pkg::STAT_OFF);
      `CHK(irq, 1'b0)
      wr(chl_pkg::MASK_OFF, 32'h0000_0002);
      rd(chl_pkg::STAT_OFF);
      `CHK(irq, 1'b1)
      wr(chl_pkg::STAT_OFF, 32'h0000_0002);
      rd(chl_pkg::STAT_OFF);
      `CHK(irq, 1'b0)
      // half duplex: flags clear by a count once a channel was enabled
      wr(chl_pkg::MODE_OFF, 32'h0000_0004);
      wr(chl_pkg::MASK_OFF, 32'h0000_0060);
      rd(chl_pkg::STAT_OFF);
      `CHK(irq, 1'b1)
      wr(chl_pkg::TXCNT_OFF, 32'h0000_0004);
      rd(chl_pkg::STAT_OFF);
      `CHK(r[6:5], 2'h0)
      `CHK(irq, 1'b0)
      // short count refused; padded count with true length works
      k0 = oe_cnt;
      cmd(32'h0000_0198);
      stat_after(800);
      `CHK(r[chl_pkg::ST_DATADONE], 1'b0)
      `CHK(oe_cnt, k0)
      wr(chl_pkg::BLK_OFF, 32'h0001_0004);
      wr(chl_pkg::TXCNT_OFF, 32'h0000_000C);
      wr(chl_pkg::DATA_OFF, 32'h3C5A_F00F);
      cmd(32'h0000_0198);
      wait_bit(chl_pkg::ST_DATADONE, 1'b1);
      `CHK(r[chl_pkg::ST_DATADONE], 1'b1)
      `CHK(cap, 32'h3C5A_F00F)
      // read whose start bit stands for one card clock, ones after it
      wr(chl_pkg::STAT_OFF, 32'h0000_0002);
      wr(chl_pkg::RXCNT_OFF, 32'h0000_0004);
      wr(chl_pkg::DMACTL_OFF, 32'h0000_0003);
      cmd(32'h0000_0091);
      @(posedge clk_sys_i);
      busy_c <= 1'b1;
      repeat (8) @(posedge clk_sys_i);
      busy_c <= 1'b0;
      wait_bit(chl_pkg::ST_DATADONE, 1'b1);
      `CHK(r[8:7], 2'h0)
      `CHK(r[4:3], 2'h3)
      rd(chl_pkg::DATA_OFF);
      `CHK(r, 32'hFFFF_FFFF)
      // reset in mid-run: flags start set, half duplex keeps them stale
      @(posedge clk_sys_i);
      rst_n_i <= 1'b0;
      repeat (2) @(posedge clk_sys_i);
      `CHK({irq, dat0, dat0_oe, slot_b}, 4'h4)
      rst_n_i <= 1'b1;
      rd(chl_pkg::STAT_OFF);
      `CHK(r, {23'h0, chl_pkg::STAT_RST})
      wr(chl_pkg::TXCNT_OFF, 32'h0000_000C);
      rd(chl_pkg::STAT_OFF);
      `CHK(r[6:5], 2'h0)
      wr(chl_pkg::MODE_OFF, 32'h0000_0004);
      wr(chl_pkg::RXCNT_OFF, 32'h0000_0004);
      rd(chl_pkg::STAT_OFF);
      `CHK(r[4:3], 2'h3)
      wr(chl_pkg::DMACTL_OFF, 32'h0000_0001);
      wr(chl_pkg::MASK_OFF, 32'h0000_0018);
      rd(chl_pkg::STAT_OFF);
      `CHK(r[4:3], 2'h0)
      `CHK(irq, 1'b0)
      finish_test();
   end
endmodule : chl_card_host_tb
